// ### bench/psrc_ctrl_monitor.sv
// assertions on the ports of the system_control_two block
`timescale 1ns/1ps
`default_nettype none
module psrc_ctrl_monitor (
  // watched ports
  input wire logic       i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_active, i_sleep_state,
  input wire logic       o_reg_rd_hit, o_sys_rst, o_host_if_rst, o_in_sleep,
  input wire logic       o_output_shift_check_enable, o_auto_sleep_enable,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire logic [2:0] i_wake_odr_sel, o_eff_odr,
  input wire logic [1:0] i_sleep_sample_rate_select, o_eff_scheme,
  input wire logic [1:0] o_sleep_oversampling_scheme, o_awake_oversampling_scheme
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [7:0] fld;
  logic       hit;
  logic [6:0] boot_n_q;
  // register image and taken-access qualifier
  assign fld = {o_output_shift_check_enable, 2'h0, o_sleep_oversampling_scheme,
                o_auto_sleep_enable, o_awake_oversampling_scheme};
  assign hit = (i_reg_addr == 8'h2B) && !o_sys_rst;
  // counts cycles spent in the boot sequence
  always_ff @(posedge i_mclk) begin
    if (!i_nrst || !o_sys_rst)
      boot_n_q <= 7'h00;
    else
      boot_n_q <= boot_n_q + 7'h01;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_write;
    i_reg_wr && hit && !i_reg_wdata[6] |=> fld == ($past(i_reg_wdata) & 8'h9F);
  endproperty
  a_write: assert property (p_write) else $error("written fields wrong");
  property p_read;
    i_reg_rd && hit |=> o_reg_rd_hit && o_reg_rdata == $past(fld);
  endproperty
  a_read: assert property (p_read) else $error("read answer wrong");
  property p_rd_zero;
    o_reg_rdata[6:5] == 2'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("bits 6 or 5 read set");
  property p_reboot;
    i_reg_wr && hit && i_reg_wdata[6] |=> o_sys_rst && o_host_if_rst && fld == 8'h00;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot did not start");
  property p_boot_len;
    $fell(o_sys_rst) |-> boot_n_q == 7'h28;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot length wrong");
  property p_refuse;
    o_sys_rst && i_reg_rd |=> !o_reg_rd_hit;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read answered in boot");
  property p_sleep;
    o_auto_sleep_enable && i_active && i_sleep_state && !o_sys_rst |=> o_in_sleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_nosleep;
    !o_auto_sleep_enable |=> !o_in_sleep;
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("sleep while disabled");
  property p_scheme;
    o_eff_scheme == (o_in_sleep ? $past(o_sleep_oversampling_scheme) : $past(o_awake_oversampling_scheme));
  endproperty
  a_scheme: assert property (p_scheme) else $error("scheme select wrong");
  property p_odr;
    o_eff_odr == (o_in_sleep ? {1'b1, $past(i_sleep_sample_rate_select)} : $past(i_wake_odr_sel));
  endproperty
  a_odr: assert property (p_odr) else $error("rate select wrong");
  // main scenarios
  c_boot: cover property ($fell(o_sys_rst));
  c_sleep: cover property (o_in_sleep);
  c_read: cover property (o_reg_rd_hit);
endmodule // psrc_ctrl_monitor
bind psrc_ctrl psrc_ctrl_monitor u_mon (.i_mclk, .i_nrst, .i_reg_wr, .i_reg_rd, .i_active,
  .i_sleep_state, .o_reg_rd_hit, .o_sys_rst, .o_host_if_rst, .o_in_sleep, .o_output_shift_check_enable,
  .o_auto_sleep_enable, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_wake_odr_sel, .o_eff_odr,
  .i_sleep_sample_rate_select, .o_eff_scheme, .o_sleep_oversampling_scheme, .o_awake_oversampling_scheme);
`default_nettype wire

// ### bench/psrc_host_model.sv
// host side model driving the register port of the system_control_two block
`timescale 1ns/1ps
`default_nettype none
module psrc_host_model (
  // clock
  input  wire logic       i_mclk,
  // register port
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // ------------------------------------------------------------
  // idle bus, then one-cycle accesses after an optional delay
  // ------------------------------------------------------------
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // write access; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(negedge i_mclk);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // read access; returns in the cycle where the answer stands
  task automatic rd(input logic [7:0] a, input int gap);
    repeat (gap) @(negedge i_mclk);
    @(negedge i_mclk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_mclk);
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule // psrc_host_model
`default_nettype wire

// ### bench/test_power_scheme_reset_control.sv
// self-checking bench for the system_control_two block
`timescale 1ns/1ps
`default_nettype none
module test_power_scheme_reset_control;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_active, i_sleep_state, o_reg_rd_hit;
  logic        o_sys_rst, o_host_if_rst, o_in_sleep, o_output_shift_check_enable, o_auto_sleep_enable;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, fld;
  logic [2:0]  i_wake_odr_sel, o_eff_odr;
  logic [1:0]  i_sleep_sample_rate_select, o_eff_scheme, o_sleep_oversampling_scheme, o_awake_oversampling_scheme;
  logic [10:0] o_os_ratio;
  logic [31:0] rs = 32'h0000003C;
  int          fails = 0, samples_checked = 0, cyc = 0;
  assign fld = {o_output_shift_check_enable, 2'h0, o_sleep_oversampling_scheme,
                o_auto_sleep_enable, o_awake_oversampling_scheme};
  psrc_host_model u_host (.i_mclk, .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  psrc_ctrl u_psrc_ctrl (.i_mclk, .i_nrst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rd_hit, .i_active, .i_sleep_state, .i_wake_odr_sel, .i_sleep_sample_rate_select, .o_sys_rst,
    .o_host_if_rst, .o_output_shift_check_enable, .o_auto_sleep_enable, .o_sleep_oversampling_scheme,
    .o_awake_oversampling_scheme, .o_in_sleep, .o_eff_scheme, .o_eff_odr, .o_os_ratio);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  // expected oversampling ratio per scheme and rate code
  function automatic logic [10:0] exp_ratio(input logic [1:0] s, input logic [2:0] r);
    case (s)
      2'h0: return r == 3'h7 ? 11'h080 : r == 3'h6 ? 11'h020 : r == 3'h5 ? 11'h010 : r == 3'h0 ? 11'h002 : 11'h004;
      2'h1: return r == 3'h7 ? 11'h020 : r == 3'h6 ? 11'h008 : r == 3'h0 ? 11'h002 : 11'h004;
      2'h2: return r == 3'h7 ? 11'h400 : r == 3'h6 ? 11'h100 : r == 3'h5 ? 11'h080 : 11'h002 << r;
      default: return r == 3'h7 ? 11'h010 : r == 3'h6 ? 11'h004 : 11'h002;
    endcase
  endfunction
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: %h vs %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] a, d, mv;
    logic [1:0] s;
    i_nrst = 1'b0;
    i_active = 1'b0;
    i_sleep_state = 1'b0;
    i_wake_odr_sel = 3'h0;
    i_sleep_sample_rate_select = 2'h0;
    repeat (12) @(negedge i_mclk);
    i_nrst = 1'b1;
    u_host.rd(8'h2B, 0);
    chk(11'({o_reg_rd_hit, o_reg_rdata}), 11'h100, "reset value");
    chk(o_os_ratio, 11'h002, "reset ratio");
    $display("reset test done");
    mv = 8'h00;
    for (int i = 0; i < 16; i++) begin
      d = i == 0 ? 8'hBF : i == 1 ? 8'h20 : rnd() & 8'hBF;
      a = (i % 4 == 3) ? rnd() | 8'h80 : 8'h2B;
      u_host.wr(a, d, i % 3);
      mv = a == 8'h2B ? d & 8'h9F : mv;
      u_host.rd(8'h2B, i % 2);
      chk(11'({o_reg_rd_hit, o_reg_rdata}), 11'({1'b1, mv}), "read back");
      chk(11'(fld), 11'(mv), "field outputs");
    end
    $display("register test done");
    i_active = 1'b1;
    i_sleep_state = 1'b1;
    for (int k = 0; k < 32; k++) begin
      s = 2'(k >> 3);
      i_wake_odr_sel = 3'(k);
      i_sleep_sample_rate_select = 2'(rnd());
      u_host.wr(8'h2B, {3'h0, ~s, 1'b0, s}, 0);
      repeat (3) @(negedge i_mclk);
      chk(11'({o_in_sleep, o_eff_scheme, o_eff_odr}), 11'({1'b0, s, 3'(k)}), "wake select");
      chk(o_os_ratio, exp_ratio(s, 3'(k)), "wake ratio");
      u_host.wr(8'h2B, {3'h0, s, 1'b1, ~s}, 0);
      repeat (3) @(negedge i_mclk);
      chk(11'({o_in_sleep, o_eff_scheme, o_eff_odr}), 11'({1'b1, s, 1'b1, i_sleep_sample_rate_select}),
          "sleep select");
      chk(o_os_ratio, exp_ratio(s, {1'b1, i_sleep_sample_rate_select}), "sleep ratio");
    end
    $display("scheme test done");
    u_host.wr(8'h2B, 8'h5F, 0);
    chk(11'({o_sys_rst, o_host_if_rst, fld}), 11'h300, "reboot start");
    u_host.wr(8'h2B, 8'h9F, 0);
    n = 3;
    repeat (60) begin
      @(negedge i_mclk);
      if (o_sys_rst === 1'b1)
        n++;
    end
    chk(11'(n), 11'h028, "boot length");
    u_host.rd(8'h2B, 0);
    chk(11'({o_reg_rd_hit, o_reg_rdata, o_in_sleep}), 11'h200, "after reboot");
    $display("reboot test done");
    wrap_up;
  end
endmodule // test_power_scheme_reset_control
`default_nettype wire

// ### hw/psrc_ctrl.sv
// system_control_two register: self test, software reboot, auto sleep, scheme select
//
// How it works
// - setting bit 7 turns on the output shift check so the three axis outputs move, clear is off and default.
// - writing 1 to the reboot trigger bit resets the device at once in standby, wake or sleep operation.
// - during the reboot every register goes back to its default value.
// - the reboot also resets the serial host interface logic so no half transfer corrupts data.
// - the reboot trigger clears itself when the boot sequence ends and always reads as zero.
// - bits 4 to 3 pick the oversampling scheme used in sleep operation, default 00.
// - bits 1 to 0 pick the oversampling scheme used in wake operation, default 00.
// - both selectors share one encoding (normal, low-noise low-power, high resolution, low power) and act apart.
// - bit 2 enables automatic sleep, clear is off and default.
// - normal and high resolution ratios follow their table per output rate.
// - low-noise low-power and low power ratios follow their table per output rate.
// - in automatic sleep the whole device runs at the sleep sample rate, overriding the wake rate.
// - with automatic sleep off the device only moves between standby and wake, never sleep.
`timescale 1ns/1ps
`default_nettype none

module psrc_ctrl (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,

  // register access from the serial host interface
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_rd_hit,

  // operating state from the rest of the device
  input  wire logic        i_active,
  input  wire logic        i_sleep_state,
  input  wire logic [2:0]  i_wake_odr_sel,
  input  wire logic [1:0]  i_sleep_sample_rate_select,

  // reboot outputs
  output logic             o_sys_rst,
  output logic             o_host_if_rst,

  // control outputs
  output logic             o_output_shift_check_enable,
  output logic             o_auto_sleep_enable,
  output logic [1:0]       o_sleep_oversampling_scheme,
  output logic [1:0]       o_awake_oversampling_scheme,
  output logic             o_in_sleep,
  output logic [1:0]       o_eff_scheme,
  output logic [2:0]       o_eff_odr,
  output logic [10:0]      o_os_ratio
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  psrc_pkg::psrc_ctrl_q_t q;
  psrc_pkg::psrc_ctrl_q_t d;

  logic wr_hit;
  logic rd_hit;

  // access decode
  assign wr_hit = i_reg_wr && (i_reg_addr == psrc_pkg::PSRC_ADDR_SYSCTL2);
  assign rd_hit = i_reg_rd && (i_reg_addr == psrc_pkg::PSRC_ADDR_SYSCTL2);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        sleeping;
    logic [2:0]  sleep_odr;
    sleeping  = 1'b0;
    sleep_odr = 3'h0;
    d         = q;

    // one cycle read answer, dropped when not addressed
    d.rd_hit  = 1'b0;
    d.rd_data = 8'h00;

    case (q.state)
      psrc_pkg::PSRC_RUN: begin
        d.sys_rst     = 1'b0;
        d.host_if_rst = 1'b0;
        if (wr_hit && i_reg_wdata[psrc_pkg::PSRC_BIT_REBOOT]) begin
          // reboot wins over any other field of the same write
          d.state       = psrc_pkg::PSRC_BOOT;
          d.boot_cnt    = psrc_pkg::PSRC_BOOT_CYCLES;
          d.sys_rst     = 1'b1;
          d.host_if_rst = 1'b1;
          d.check_en    = psrc_pkg::PSRC_SYSCTL2_RESET[psrc_pkg::PSRC_BIT_CHECK];
          d.sleep_oversampling_scheme       = psrc_pkg::PSRC_SYSCTL2_RESET[psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_LO];
          d.sleep_en    = psrc_pkg::PSRC_SYSCTL2_RESET[psrc_pkg::PSRC_BIT_SLEEP_EN];
          d.awake_oversampling_scheme        = psrc_pkg::PSRC_SYSCTL2_RESET[psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_LO];
        end else if (wr_hit) begin
          d.check_en = i_reg_wdata[psrc_pkg::PSRC_BIT_CHECK];
          d.sleep_oversampling_scheme    = i_reg_wdata[psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_LO];
          d.sleep_en = i_reg_wdata[psrc_pkg::PSRC_BIT_SLEEP_EN];
          d.awake_oversampling_scheme     = i_reg_wdata[psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_LO];
        end
        if (rd_hit) begin
          d.rd_hit = 1'b1;
          d.rd_data[psrc_pkg::PSRC_BIT_CHECK]    = q.check_en;
          d.rd_data[psrc_pkg::PSRC_BIT_REBOOT]   = 1'b0;
          d.rd_data[psrc_pkg::PSRC_BIT_RSVD]     = 1'b0;
          d.rd_data[psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_LO] = q.sleep_oversampling_scheme;
          d.rd_data[psrc_pkg::PSRC_BIT_SLEEP_EN] = q.sleep_en;
          d.rd_data[psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_HI:psrc_pkg::PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_LO]   = q.awake_oversampling_scheme;
        end
      end

      psrc_pkg::PSRC_BOOT: begin
        // accesses are ignored while the serial interface is held in reset
        d.sys_rst     = 1'b1;
        d.host_if_rst = 1'b1;
        d.boot_cnt    = q.boot_cnt - 6'h01;
        if (q.boot_cnt == 6'h01) begin
          // end of boot: trigger falls back to zero
          d.state       = psrc_pkg::PSRC_RUN;
          d.boot_cnt    = 6'h00;
          d.sys_rst     = 1'b0;
          d.host_if_rst = 1'b0;
        end
      end

      default: begin
        d.state = psrc_pkg::PSRC_RUN;
      end
    endcase

    // sleep only when automatic sleep is on and the device is active
    sleeping   = q.sleep_en && i_active && i_sleep_state && (q.state == psrc_pkg::PSRC_RUN);
    d.in_sleep = sleeping;

    // scheme chosen by operating state, selectors kept apart
    d.eff_scheme = sleeping ? q.sleep_oversampling_scheme : q.awake_oversampling_scheme;

    // sleep sample rate overrides the wake rate for every block
    sleep_odr = psrc_pkg::PSRC_SLEEP_ODR_MAP[4'(i_sleep_sample_rate_select) * 4'h3 +: 3]; // 3-bit entries
    d.eff_odr = sleeping ? sleep_odr : i_wake_odr_sel;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // oversampling ratio for the scheme and rate now in use
  // ---------------------------------------------------------------
  psrc_os_lut u_os_lut (
    .i_mclk   (i_mclk),
    .i_nrst   (i_nrst),
    .i_scheme (q.eff_scheme),
    .i_odr    (q.eff_odr),
    .o_ratio  (o_os_ratio)
  );

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign o_reg_rdata                 = q.rd_data;
  assign o_reg_rd_hit                = q.rd_hit;
  assign o_sys_rst                   = q.sys_rst;
  assign o_host_if_rst               = q.host_if_rst;
  assign o_output_shift_check_enable = q.check_en;
  assign o_auto_sleep_enable         = q.sleep_en;
  assign o_sleep_oversampling_scheme = q.sleep_oversampling_scheme;
  assign o_awake_oversampling_scheme = q.awake_oversampling_scheme;
  assign o_in_sleep                  = q.in_sleep;
  assign o_eff_scheme                = q.eff_scheme;
  assign o_eff_odr                   = q.eff_odr;

endmodule // psrc_ctrl

`default_nettype wire

// ### hw/psrc_os_lut.sv
// oversampling ratio lookup for the selected scheme and rate code
`timescale 1ns/1ps
`default_nettype none

module psrc_os_lut (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // selection
  input  wire logic [1:0]  i_scheme,
  input  wire logic [2:0]  i_odr,
  // result
  output logic [10:0]      o_ratio
);

  psrc_pkg::psrc_lut_q_t q;
  psrc_pkg::psrc_lut_q_t d;

  // ---------------------------------------------------------------
  // table lookup, ratio = 2 ** exponent
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] row;
    logic [3:0]  expo;
    row  = psrc_pkg::PSRC_EXP_NORMAL;
    expo = 4'h0;
    case (i_scheme)
      psrc_pkg::PSRC_SCH_NORMAL: row = psrc_pkg::PSRC_EXP_NORMAL;
      psrc_pkg::PSRC_SCH_LNLP:   row = psrc_pkg::PSRC_EXP_LNLP;
      psrc_pkg::PSRC_SCH_HIRES:  row = psrc_pkg::PSRC_EXP_HIRES;
      psrc_pkg::PSRC_SCH_LOWPWR: row = psrc_pkg::PSRC_EXP_LOWPWR;
      default:                   row = psrc_pkg::PSRC_EXP_NORMAL;
    endcase
    expo    = row[{i_odr, 2'h0} +: 4];
    d.ratio = 11'h001 << expo;
  end

  // ---------------------------------------------------------------
  // result register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_ratio = q.ratio;

endmodule // psrc_os_lut

`default_nettype wire

// ### hw/psrc_pkg.sv
// constants and types shared by the power scheme and reset control block
package psrc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PSRC_ADDR_SYSCTL2   = 8'h2B; // system_control_two
  localparam logic [7:0] PSRC_SYSCTL2_RESET  = 8'h00; // value after any reset

  // field positions in system_control_two
  localparam int PSRC_BIT_CHECK    = 7; // output_shift_check_enable
  localparam int PSRC_BIT_REBOOT   = 6; // software reboot trigger
  localparam int PSRC_BIT_RSVD     = 5; // reserved, reads zero
  localparam int PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_HI = 4; // sleep_oversampling_scheme
  localparam int PSRC_BIT_SLEEP_OVERSAMPLING_SCHEME_LO = 3;
  localparam int PSRC_BIT_SLEEP_EN = 2; // auto_sleep_enable
  localparam int PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_HI  = 1; // awake_oversampling_scheme
  localparam int PSRC_BIT_AWAKE_OVERSAMPLING_SCHEME_LO  = 0;

  // ---------------------------------------------------------------
  // scheme encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] PSRC_SCH_NORMAL = 2'h0;
  localparam logic [1:0] PSRC_SCH_LNLP   = 2'h1;
  localparam logic [1:0] PSRC_SCH_HIRES  = 2'h2;
  localparam logic [1:0] PSRC_SCH_LOWPWR = 2'h3;

  // ---------------------------------------------------------------
  // oversampling ratio as log2, one nibble per rate code
  // rate code 0..7 = 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
  // ---------------------------------------------------------------
  localparam logic [31:0] PSRC_EXP_NORMAL = 32'h7542_2221; // 128 32 16 4 4 4 4 2
  localparam logic [31:0] PSRC_EXP_LNLP   = 32'h5322_2221; // 32 8 4 then normal
  localparam logic [31:0] PSRC_EXP_HIRES  = 32'hA875_4321; // 1024 down to 2
  localparam logic [31:0] PSRC_EXP_LOWPWR = 32'h4211_1111; // 16 4 then 2

  // sleep rate select 00..11 mapped onto rate codes (50, 12.5, 6.25, 1.56 Hz)
  localparam logic [11:0] PSRC_SLEEP_ODR_MAP = 12'hFAC; // {3'h7,3'h6,3'h5,3'h4}, three bits per select

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PSRC_CLK_PERIOD_NS = 25;   // 40 MHz clock
  localparam int PSRC_BOOT_TIME_NS  = 1000; // length of the boot sequence
  localparam logic [5:0] PSRC_BOOT_CYCLES =
    6'((PSRC_BOOT_TIME_NS + PSRC_CLK_PERIOD_NS - 1) / PSRC_CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {PSRC_RUN, PSRC_BOOT} psrc_state_t;

  typedef struct packed {
    psrc_state_t state;
    logic [5:0]  boot_cnt;
    logic        check_en;
    logic [1:0]  sleep_oversampling_scheme;
    logic        sleep_en;
    logic [1:0]  awake_oversampling_scheme;
    logic        in_sleep;
    logic [1:0]  eff_scheme;
    logic [2:0]  eff_odr;
    logic        sys_rst;
    logic        host_if_rst;
    logic [7:0]  rd_data;
    logic        rd_hit;
  } psrc_ctrl_q_t;

  typedef struct packed {
    logic [10:0] ratio;
  } psrc_lut_q_t;

endpackage : psrc_pkg
